// ---- tb/bie_exec_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module bie_exec_sva (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [13:0] instr,
    input wire logic        instr_valid,
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_we,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  acc_out,
    input wire logic        zero_flag,
    input wire logic        skip_taken,
    input wire logic        busy_flush
);
    logic       go;
    logic [7:0] bm;
    // flush slot never counts as an instruction
    assign go = instr_valid && !busy_flush;
    assign bm = 8'h01 << instr[9:7];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_clr; go && instr[13:10] == 4'h4 |=> reg_we && reg_wdata == ($past(reg_rdata) & ~$past(bm)); endproperty
    a_clr: assert property (p_clr) else $error("bit clear wrong");
    property p_set; go && instr[13:10] == 4'h5 |=> reg_we && reg_wdata == ($past(reg_rdata) | $past(bm)); endproperty
    a_set: assert property (p_set) else $error("bit set wrong");
    property p_tst; skip_taken == (go && instr[13:10] == 4'h6 && (reg_rdata & bm) == 8'h00); endproperty
    a_tst: assert property (p_tst) else $error("skip wrong");
    property p_fls; skip_taken |=> busy_flush ##1 !busy_flush; endproperty
    a_fls: assert property (p_fls) else $error("flush slot wrong");
    property p_ign; busy_flush |=> !reg_we && $stable(acc_out) && $stable(zero_flag); endproperty
    a_ign: assert property (p_ign) else $error("flush slot executed");
    property p_flg; go && instr[13:12] == 2'h1 |=> $stable(zero_flag) && $stable(acc_out); endproperty
    a_flg: assert property (p_flg) else $error("bit op touched flags");
    property p_wcl; go && instr == 14'h0103 |=> acc_out == 8'h00 && zero_flag; endproperty
    a_wcl: assert property (p_wcl) else $error("acc clear wrong");
    property p_inv; go && instr[13:7] == 7'h13 |=> reg_we && reg_wdata == ~$past(reg_rdata) && $stable(acc_out)
        && zero_flag == (reg_wdata == 8'h00); endproperty
    a_inv: assert property (p_inv) else $error("invert to reg wrong");
    property p_ivw; go && instr[13:7] == 7'h12 |=> !reg_we && acc_out == ~$past(reg_rdata)
        && zero_flag == (acc_out == 8'h00); endproperty
    a_ivw: assert property (p_ivw) else $error("invert to acc wrong");
endmodule
bind bie_exec bie_exec_sva u_sva (.*);
`default_nettype wire

// ---- tb/bie_regfile_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module bie_regfile_model (
    input wire logic       clock,
    input wire logic [6:0] reg_addr,
    input wire logic       reg_we,
    input wire logic [7:0] reg_wdata,
    output logic [7:0]     reg_rdata
);
    logic [7:0] mem [128];
    logic [6:0] waddr_r;
    // no bypass: a write lands one edge after the strobe, like the real file
    assign reg_rdata = mem[reg_addr];
    always @(posedge clock) begin
        waddr_r <= reg_addr;
        if (reg_we) mem[waddr_r] <= reg_wdata;
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("Error %s exp %0h got %0h", nm, e, a); end end
module testbench;
    logic        clock = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, reg_we, zero_flag, skip_taken, busy_flush;
    logic [13:0] instr = 14'h0000, w;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_rdata, reg_wdata, acc_out;
    int          n_fail = 0, cmp_count = 0, cyc = 0, m[128], acc = 0, z = 0, fl = 0, sk, f, b, k, a, pf = 0;
    always #5 clock = ~clock;
    bie_exec dut (.*);
    bie_regfile_model u_rf (.*);
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // one instruction at the falling edge; skip is checked in-cycle, results after the edge
    task automatic step(input logic v, input logic [13:0] iw);
        int r;
        instr_valid = v;
        instr = iw;
        f = iw[6:0];
        b = iw[9:7];
        sk = 0;
        #1;
        `CHK("flush", fl, busy_flush)
        `CHK("addr", f, reg_addr)
        if (fl) fl = 0;
        else if (v) begin
            case (iw[13:10])
                4'h4: m[f] &= ~(1 << b);
                4'h5: m[f] |= 1 << b;
                4'h6: sk = (m[f] >> b) & 1 ^ 1;
            endcase
            if (iw == 14'h0103) begin
                acc = 0;
                z = 1;
            end
            if (iw[13:8] == 6'h09) begin
                r = ~m[f] & 255;
                z = r == 0;
                if (iw[7]) m[f] = r;
                else acc = r;
            end
            fl = sk;
        end
        `CHK("skip", sk, skip_taken)
        @(negedge clock);
        `CHK("acc", acc, acc_out)
        `CHK("zero", z, zero_flag)
    endtask
    initial begin
        void'($urandom(32'h0BB9));
        for (int i = 0; i < 128; i++) begin
            m[i] = ($urandom % 2) ? 255 : $urandom % 256;
            u_rf.mem[i] = 8'(m[i]);
        end
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        // back to back; address differs from the last one since the file has no bypass
        for (int n = 0; n < 600; n++) begin
            // second reset mid-run: a pending write still lands, flags and state return to idle
            if (n == 300) begin
                rst_n = 1'b0;
                instr_valid = 1'b0;
                repeat (2) @(negedge clock);
                `CHK("rst acc", 0, acc_out)
                `CHK("rst zero", 0, zero_flag)
                `CHK("rst flush", 0, busy_flush)
                `CHK("rst we", 0, reg_we)
                rst_n = 1'b1;
                acc = 0;
                z = 0;
                fl = 0;
            end
            k = $urandom % 7;
            a = $urandom % 128;
            if (a == pf) a = (a + 1) % 128;
            case (k)
                0, 1, 2: w = {4'h4 + 4'(k), 3'($urandom), 7'(a)};
                3: w = 14'h0103;
                4: w = {6'h09, 1'($urandom), 7'(a)};
                default: w = 14'($urandom) | 14'h3000;
            endcase
            step(k != 6, w);
            pf = a;
        end
        instr_valid = 1'b0;
        @(negedge clock);
        for (int i = 0; i < 128; i++) `CHK("reg", m[i], u_rf.mem[i])
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- verilog/bie_dec_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// decoded fields passed from the decoder to the executor
interface bie_dec_if;
    import bie_pkg::*;
    bie_kind_type kind;
    logic [6:0]   fidx;
    logic [2:0]   bpos;
    logic         dest;
    modport dec (output kind, fidx, bpos, dest);
    modport exe (input kind, fidx, bpos, dest);
endinterface
`default_nettype wire

// ---- verilog/bie_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bie_params.svh"
module bie_decoder
    import bie_pkg::*;
(
    input  wire logic [13:0] instr,
    bie_dec_if.dec           dec
);
    // -----------------------------------------------------------------
    // field extraction and opcode match
    // -----------------------------------------------------------------
    assign dec.fidx = instr[`BIE_FIDX_W-1:0];
    assign dec.bpos = instr[`BIE_BPOS_LSB+2:`BIE_BPOS_LSB];
    assign dec.dest = instr[`BIE_DEST_BIT];

    // anything not matched decodes as nop, so unknown words never write
    always_comb begin
        dec.kind = BIE_K_NOP;
        if (instr[13:10] == `BIE_OP_BITCLR) begin
            dec.kind = BIE_K_BITCLR;
        end else if (instr[13:10] == `BIE_OP_BITSET) begin
            dec.kind = BIE_K_BITSET;
        end else if (instr[13:10] == `BIE_OP_BITTST) begin
            dec.kind = BIE_K_BITTST;
        end else if (instr == `BIE_OP_WCLR) begin
            dec.kind = BIE_K_WCLR;
        end else if (instr[13:8] == `BIE_OP_INV) begin
            dec.kind = BIE_K_INV;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/bie_exec.sv ----
// How it works
// - bit clear zeroes bit b of register f, other bits kept
// - bit set forces bit b of register f to one
// - bit test skips the next instruction only when the bit is zero
// - on skip the prefetched word is dropped and a nop runs instead
// - bit test takes one cycle, two when the skip is taken
// - accumulator clear loads zero and sets the zero flag, one cycle
// - invert complements register f into accumulator (d=0) or f (d=1), updates zero
`timescale 1ns/1ns
`default_nettype none
`include "bie_params.svh"
module bie_exec
    import bie_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [13:0] instr,
    input  wire logic        instr_valid,
    output logic [6:0]       reg_addr,
    input  wire logic [7:0]  reg_rdata,
    output logic             reg_we,
    output logic [7:0]       reg_wdata,
    output logic [7:0]       acc_out,
    output logic             zero_flag,
    output logic             skip_taken,
    output logic             busy_flush
);
    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    bie_dec_if dec_bus ();

    bie_decoder u_dec (
        .instr (instr),
        .dec   (dec_bus)
    );

    // -----------------------------------------------------------------
    // state and working values
    // -----------------------------------------------------------------
    bie_state_type state_r;
    bie_state_type state_nxt;
    bie_kind_type  kind;
    logic [7:0]    bit_mask;
    logic [7:0]    bit_clr_val;
    logic [7:0]    bit_set_val;
    logic [7:0]    inv_val;
    logic          inv_zero;
    logic          tested_bit;
    logic [7:0]    acc_r;
    logic          zero_r;
    logic [7:0]    wdata_r;
    logic [7:0]    wdata_nxt;
    logic          we_r;
    logic          we_nxt;

    // -----------------------------------------------------------------
    // slot qualification
    // -----------------------------------------------------------------
    // a flushed slot always executes as nop, whatever was fetched; fetch keeps
    // running during the skip, so the dropped word is squashed here
    // discard prefetched word
    assign kind = (state_r == BIE_S_FLUSH || !instr_valid) ? BIE_K_NOP : dec_bus.kind;

    // the file answers in the same cycle, so reads need no extra stage
    assign reg_addr = dec_bus.fidx;
    assign inv_val  = ~reg_rdata;
    assign inv_zero = (inv_val == 8'h00);

    // -----------------------------------------------------------------
    // per-bit select and read-modify-write
    // -----------------------------------------------------------------
    // one slice per data bit: only the selected position is altered, the
    // other seven carry the value read this cycle straight through
    for (genvar gi = 0; gi < 8; gi++) begin : g_bit
        assign bit_mask[gi]    = (dec_bus.bpos == 3'(gi));
        assign bit_clr_val[gi] = bit_mask[gi] ? 1'b0 : reg_rdata[gi];
        assign bit_set_val[gi] = bit_mask[gi] ? 1'b1 : reg_rdata[gi];
    end

    // the mask is one-hot, so the or of the masked byte is the tested bit
    assign tested_bit = |(reg_rdata & bit_mask);
    assign skip_taken = (kind == BIE_K_BITTST) && !tested_bit;
    assign busy_flush = (state_r == BIE_S_FLUSH);

    // -----------------------------------------------------------------
    // register write-back
    // -----------------------------------------------------------------
    // strobe and data are chosen here and registered below; the write lands
    // a cycle late and the file has no bypass, a limitation software must know
    always_comb begin
        we_nxt    = 1'b0;
        wdata_nxt = wdata_r;
        case (kind)
            BIE_K_BITCLR: begin
                we_nxt    = 1'b1;
                wdata_nxt = bit_clr_val;
            end
            BIE_K_BITSET: begin
                we_nxt    = 1'b1;
                wdata_nxt = bit_set_val;
            end
            BIE_K_INV: begin
                we_nxt    = dec_bus.dest;
                wdata_nxt = inv_val;
            end
            // bit test, accumulator clear and nop write nothing
            default: begin
                we_nxt    = 1'b0;
                wdata_nxt = wdata_r;
            end
        endcase
    end

    // write strobe: a single-cycle pulse per writing instruction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            we_r <= 1'b0;
        end else begin
            we_r <= we_nxt;
        end
    end

    // write data moves on each write and on invert with d=0, and holds for every other instruction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wdata_r <= `BIE_WD_RST;
        end else begin
            wdata_r <= wdata_nxt;
        end
    end

    assign reg_we    = we_r;
    assign reg_wdata = wdata_r;

    // -----------------------------------------------------------------
    // accumulator and zero flag
    // -----------------------------------------------------------------
    // accumulator: only clear and invert with d=0 load it
    // flags untouched
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_r <= `BIE_W_RST;
        end else begin
            case (kind)
                BIE_K_WCLR: begin
                    acc_r <= 8'h00;
                end
                BIE_K_INV: begin
                    if (!dec_bus.dest) begin
                        acc_r <= inv_val;
                    end
                end
                default: begin
                    acc_r <= acc_r;
                end
            endcase
        end
    end

    // zero flag: bit operations and nop fall to the hold branch
    // flags untouched
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            zero_r <= `BIE_Z_RST;
        end else begin
            case (kind)
                BIE_K_WCLR: begin
                    zero_r <= 1'b1;
                end
                BIE_K_INV: begin
                    zero_r <= inv_zero;
                end
                default: begin
                    zero_r <= zero_r;
                end
            endcase
        end
    end

    assign acc_out   = acc_r;
    assign zero_flag = zero_r;

    // -----------------------------------------------------------------
    // skip sequencing
    // -----------------------------------------------------------------
    // second cycle on skip
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BIE_S_RUN: begin
                if (skip_taken) begin
                    state_nxt = BIE_S_FLUSH;
                end
            end
            // the dropped slot lasts exactly one cycle, then execution resumes
            BIE_S_FLUSH: begin
                state_nxt = BIE_S_RUN;
            end
            default: begin
                state_nxt = BIE_S_RUN;
            end
        endcase
    end

    // state register; reset always returns to normal execution
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= BIE_S_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/bie_params.svh ----
`ifndef BIE_PARAMS_SVH
`define BIE_PARAMS_SVH
// instruction word layout
`define BIE_IW_W          14
`define BIE_FIDX_W        7
`define BIE_BPOS_LSB      7
`define BIE_DEST_BIT      7
// opcode match values
`define BIE_OP_BITCLR     4'h4
`define BIE_OP_BITSET     4'h5
`define BIE_OP_BITTST     4'h6
`define BIE_OP_WCLR       14'h0103
`define BIE_OP_INV        6'h09
// reset values
`define BIE_W_RST         8'h00
`define BIE_WD_RST        8'h00
`define BIE_Z_RST         1'b0
`endif

// ---- verilog/bie_pkg.sv ----
`default_nettype none
package bie_pkg;
    typedef enum logic [2:0] {
        BIE_K_NOP,
        BIE_K_BITCLR,
        BIE_K_BITSET,
        BIE_K_BITTST,
        BIE_K_WCLR,
        BIE_K_INV
    } bie_kind_type;
    typedef enum logic {
        BIE_S_RUN,
        BIE_S_FLUSH
    } bie_state_type;
endpackage
`default_nettype wire
